// File: verilog/sptc_timing.v
// self-polling timing, reference prescaler, clock-out divider and trim register file
// assumes core_clk at 10 MHz, synchronous active-high srst, an Avalon-MM master with waitrequest
//
// Behaviour
// - prescaler ticks every 64 clocks; reference period is 64 times programmed value
// - reference value zero counts as 256; one gives shortest period
// - reference tick, not raw clock, advances on-time and off-time counters
// - off time equals 14-bit off count times reference period, from two registers
// - off count bits 13:8 come from bits 5:0 of second off register
// - off count zero gives 16384 reference periods; one gives one period
// - active period count is 5 bits, 1 to 31; zero means 256
// - idle period count is 8 bits, 1 to 255; zero means 256
// - 32-bit read-only serial number over four bytes, low byte lowest address
// - clock-out divider is 20 bits, bits 19:16 from third register low nibble
// - divider one gives clock divided by 2; zero gives division by 2^21
// - rf control bit 4 drives rf path disable, one switches path off
// - 4-bit if attenuation code selects one of 16 gain steps
// - 5-bit signal strength slope trim drives gain, 00h minimum, 1Fh maximum
// - on time equals 14-bit on count times reference period; zero means 16384
`include "sptc_map.vh"

module sptc_timing #(
    parameter [31:0] SERIAL_NUMBER = 32'h5a5a_1234  // arbitrary value
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        srst,
    // avalon-mm slave
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // polling timing
    output reg         referenceTick,
    output reg         pollingOnPhase,
    output reg         masterPeriodEnd,
    output reg         activeWindow,
    // clock out
    output reg         dividedClockOutput,
    // analogue trims
    output reg         rfPathDisable,
    output reg  [3:0]  ifAttenuationCode,
    output reg         injectionSideSelect,
    output reg  [4:0]  signalStrengthSlopeTrim
);

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    reg  [7:0]  pollingReferenceValue;
    reg  [7:0]  offLow;
    reg  [7:0]  offHigh;
    reg  [7:0]  activeReg;
    reg  [7:0]  idleReg;
    reg  [7:0]  divLow;
    reg  [7:0]  divMid;
    reg  [7:0]  divHigh;
    reg  [7:0]  loCtrl;
    reg  [7:0]  onLow;
    reg  [7:0]  onHigh;
    reg         pollingEnable;

    // ----------------------------------------------------------------
    // derived reload values
    // ----------------------------------------------------------------
    wire [13:0] pollingOffCount;
    wire [13:0] pollingOnCount;
    wire [4:0]  activePeriodCount;
    wire [7:0]  idlePeriodCount;
    wire [19:0] divValue;
    reg  [8:0]  refReload;
    reg  [14:0] offReload;
    reg  [14:0] onReload;
    reg  [8:0]  activeReload;
    reg  [8:0]  idleReload;
    reg  [20:0] divTarget;

    assign pollingOffCount   = {offHigh[`SPTC_HIGH6_MSB:0], offLow};
    assign pollingOnCount    = {onHigh[`SPTC_HIGH6_MSB:0], onLow};
    assign activePeriodCount = activeReg[`SPTC_ACTIVE_MSB:0];
    assign idlePeriodCount   = idleReg;
    assign divValue          = {divHigh[`SPTC_DIV_HIGH_MSB:0], divMid, divLow};


    // ----------------------------------------------------------------
    // zero maps to full range
    // ----------------------------------------------------------------
    always @* begin
        if (pollingReferenceValue == 8'h00) begin
            refReload = `SPTC_FULL_BYTE_COUNT;
        end else begin
            refReload = {1'b0, pollingReferenceValue};
        end
    end

    always @* begin
        if (pollingOffCount == 14'h0000) begin
            offReload = `SPTC_FULL_14BIT_COUNT;
        end else begin
            offReload = {1'b0, pollingOffCount};
        end
    end

    always @* begin
        if (pollingOnCount == 14'h0000) begin
            onReload = `SPTC_FULL_14BIT_COUNT;
        end else begin
            onReload = {1'b0, pollingOnCount};
        end
    end

    always @* begin
        if (activePeriodCount == 5'h00) begin
            activeReload = `SPTC_FULL_BYTE_COUNT;
        end else begin
            activeReload = {4'h0, activePeriodCount};
        end
    end

    always @* begin
        if (idlePeriodCount == 8'h00) begin
            idleReload = `SPTC_FULL_BYTE_COUNT;
        end else begin
            idleReload = {1'b0, idlePeriodCount};
        end
    end

    always @* begin
        if (divValue == 20'h00000) begin
            divTarget = 21'h100000;
        end else begin
            divTarget = {1'b0, divValue};
        end
    end


    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire [5:0]  regIndex;
    wire        busRequest;
    wire        writeCommit;
    reg  [7:0]  readValue;

    assign regIndex    = avs_address[7:2];
    assign busRequest  = avs_read | avs_write;
    assign writeCommit = avs_write & ~avs_waitrequest;

    always @* begin
        readValue = 8'h00;
        if (regIndex == `SPTC_IDX_SERIAL0) begin
            readValue = SERIAL_NUMBER[7:0];
        end else if (regIndex == `SPTC_IDX_SERIAL1) begin
            readValue = SERIAL_NUMBER[15:8];
        end else if (regIndex == `SPTC_IDX_SERIAL2) begin
            readValue = SERIAL_NUMBER[23:16];
        end else if (regIndex == `SPTC_IDX_SERIAL3) begin
            readValue = SERIAL_NUMBER[31:24];
        end else if (regIndex == `SPTC_IDX_STATUS) begin
            readValue = {4'h0, dividedClockOutput, activeWindow, pollingOnPhase, pollingEnable};
        end else if (regIndex == `SPTC_IDX_ENABLE) begin
            readValue = {7'h00, pollingEnable};
        end else begin
            readValue = 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // bus handshake: one wait cycle, write lands when waitrequest is low
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else if (busRequest && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= {24'h000000, readValue};
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        if (srst) begin
            pollingReferenceValue   <= `SPTC_RST_REF_PERIOD;
            offLow                  <= `SPTC_RST_OFF_LOW;
            offHigh                 <= `SPTC_RST_OFF_HIGH;
            activeReg               <= `SPTC_RST_ACTIVE;
            idleReg                 <= `SPTC_RST_IDLE;
            divLow                  <= `SPTC_RST_DIV_LOW;
            divMid                  <= `SPTC_RST_DIV_MID;
            divHigh                 <= `SPTC_RST_DIV_HIGH;
            loCtrl                  <= `SPTC_RST_LO_CTRL;
            onLow                   <= `SPTC_RST_ON_LOW;
            onHigh                  <= `SPTC_RST_ON_HIGH;
            pollingEnable           <= 1'b1;
            rfPathDisable           <= 1'b0;
            ifAttenuationCode       <= 4'h0;
            injectionSideSelect     <= 1'b0;
            signalStrengthSlopeTrim <= 5'h0c;
        end else if (writeCommit) begin
            if (regIndex == `SPTC_IDX_REF_PERIOD) begin
                pollingReferenceValue <= avs_writedata[7:0];
            end else if (regIndex == `SPTC_IDX_OFF_LOW) begin
                offLow <= avs_writedata[7:0];
            end else if (regIndex == `SPTC_IDX_OFF_HIGH) begin
                offHigh <= avs_writedata[7:0];
            end else if (regIndex == `SPTC_IDX_ACTIVE) begin
                activeReg <= avs_writedata[7:0];
            end else if (regIndex == `SPTC_IDX_IDLE) begin
                idleReg <= avs_writedata[7:0];
            end else if (regIndex == `SPTC_IDX_RF_CTRL) begin
                rfPathDisable     <= avs_writedata[`SPTC_RF_DISABLE_BIT];
                ifAttenuationCode <= avs_writedata[`SPTC_IF_ATT_MSB:0];
            end else if (regIndex == `SPTC_IDX_DIV_LOW) begin
                divLow <= avs_writedata[7:0];
            end else if (regIndex == `SPTC_IDX_DIV_MID) begin
                divMid <= avs_writedata[7:0];
            end else if (regIndex == `SPTC_IDX_DIV_HIGH) begin
                divHigh <= avs_writedata[7:0];
            end else if (regIndex == `SPTC_IDX_LO_CTRL) begin
                loCtrl              <= avs_writedata[7:0];
                injectionSideSelect <= avs_writedata[`SPTC_INJ_SIDE_BIT];
            end else if (regIndex == `SPTC_IDX_GAIN_TRIM) begin
                signalStrengthSlopeTrim <= avs_writedata[`SPTC_GAIN_MSB:0];
            end else if (regIndex == `SPTC_IDX_ON_LOW) begin
                onLow <= avs_writedata[7:0];
            end else if (regIndex == `SPTC_IDX_ON_HIGH) begin
                onHigh <= avs_writedata[7:0];
            end else if (regIndex == `SPTC_IDX_ENABLE) begin
                pollingEnable <= avs_writedata[`SPTC_ENABLE_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // reference prescaler and reference timer
    // ----------------------------------------------------------------
    reg  [6:0]  prescaleCnt;
    reg  [8:0]  refCnt;
    wire        prescaleTick;
    wire        refExpire;

    assign prescaleTick = (prescaleCnt == (`SPTC_PRESCALE_DIV - 7'h01));
    assign refExpire    = prescaleTick && (refCnt == 9'h001);

    always @(posedge core_clk) begin
        if (srst || !pollingEnable) begin
            prescaleCnt   <= 7'h00;
            refCnt        <= 9'h001;
            referenceTick <= 1'b0;
        end else begin
            referenceTick <= refExpire;
            if (prescaleTick) begin
                prescaleCnt <= 7'h00;
            end else begin
                prescaleCnt <= prescaleCnt + 7'h01;
            end
            if (refExpire) begin
                refCnt <= refReload;
            end else if (prescaleTick) begin
                refCnt <= refCnt - 9'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // on-time / off-time phase counter and active / idle periods
    // ----------------------------------------------------------------
    reg  [14:0] phaseCnt;
    reg  [8:0]  periodCnt;
    wire        phaseExpire;
    wire        periodExpire;

    assign phaseExpire  = referenceTick && (phaseCnt == 15'h0001);
    assign periodExpire = phaseExpire && !pollingOnPhase && (periodCnt == 9'h001);

    always @(posedge core_clk) begin
        if (srst || !pollingEnable) begin
            phaseCnt        <= 15'h0001;
            periodCnt       <= 9'h001;
            pollingOnPhase  <= 1'b0;
            activeWindow    <= 1'b0;
            masterPeriodEnd <= 1'b0;
        end else begin
            masterPeriodEnd <= phaseExpire && !pollingOnPhase;
            if (phaseExpire) begin
                pollingOnPhase <= ~pollingOnPhase;
                phaseCnt       <= pollingOnPhase ? offReload : onReload;
            end else if (referenceTick) begin
                phaseCnt <= phaseCnt - 15'h0001;
            end
            if (periodExpire) begin
                activeWindow <= ~activeWindow;
                periodCnt    <= activeWindow ? idleReload : activeReload;
            end else if (phaseExpire && !pollingOnPhase) begin
                periodCnt <= periodCnt - 9'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // clock-out divider
    // ----------------------------------------------------------------
    reg  [20:0] divCnt;
    reg  [20:0] next_divCnt;
    reg         next_dividedClockOutput;

    // counter runs 1..target, output flips at the top
    always @* begin
        next_divCnt             = divCnt + 21'h000001;
        next_dividedClockOutput = dividedClockOutput;

        if (divCnt >= divTarget) begin
            next_divCnt             = 21'h000001;
            next_dividedClockOutput = ~dividedClockOutput;
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            divCnt             <= 21'h000001;
            dividedClockOutput <= 1'b0;
        end else begin
            divCnt             <= next_divCnt;
            dividedClockOutput <= next_dividedClockOutput;
        end
    end


endmodule // sptc_timing

// File: pkg/sptc_map.vh
// register indices, field positions, reset values and counts of the polling timer block
// assumes byte address = 4 * register index, 8-bit data in the low bits of a 32-bit word
`ifndef SPTC_MAP_VH
`define SPTC_MAP_VH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define SPTC_IDX_REF_PERIOD     6'h08
`define SPTC_IDX_OFF_LOW        6'h09
`define SPTC_IDX_OFF_HIGH       6'h0a
`define SPTC_IDX_ACTIVE         6'h0b
`define SPTC_IDX_IDLE           6'h0c
`define SPTC_IDX_SERIAL0        6'h0e
`define SPTC_IDX_SERIAL1        6'h0f
`define SPTC_IDX_SERIAL2        6'h10
`define SPTC_IDX_SERIAL3        6'h11
`define SPTC_IDX_RF_CTRL        6'h12
`define SPTC_IDX_DIV_LOW        6'h13
`define SPTC_IDX_DIV_MID        6'h14
`define SPTC_IDX_DIV_HIGH       6'h15
`define SPTC_IDX_LO_CTRL        6'h16
`define SPTC_IDX_GAIN_TRIM      6'h1b
`define SPTC_IDX_ON_LOW         6'h1f
`define SPTC_IDX_ON_HIGH        6'h20
`define SPTC_IDX_STATUS         6'h30
`define SPTC_IDX_ENABLE         6'h31

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SPTC_RST_REF_PERIOD     8'h01
`define SPTC_RST_OFF_LOW        8'h01
`define SPTC_RST_OFF_HIGH       8'h00
`define SPTC_RST_ACTIVE         8'h01
`define SPTC_RST_IDLE           8'h01
`define SPTC_RST_RF_CTRL        8'h00
`define SPTC_RST_DIV_LOW        8'h07
`define SPTC_RST_DIV_MID        8'h00
`define SPTC_RST_DIV_HIGH       8'h00
`define SPTC_RST_LO_CTRL        8'h00
`define SPTC_RST_GAIN_TRIM      8'h0c
`define SPTC_RST_ON_LOW         8'h01
`define SPTC_RST_ON_HIGH        8'h00
`define SPTC_RST_ENABLE         8'h01

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SPTC_RF_DISABLE_BIT     4
`define SPTC_IF_ATT_MSB         3
`define SPTC_INJ_SIDE_BIT       4
`define SPTC_GAIN_MSB           4
`define SPTC_HIGH6_MSB          5
`define SPTC_ACTIVE_MSB         4
`define SPTC_DIV_HIGH_MSB       3
`define SPTC_ENABLE_BIT         0

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define SPTC_PRESCALE_DIV       7'h40
`define SPTC_FULL_BYTE_COUNT    9'h100
`define SPTC_FULL_14BIT_COUNT   15'h4000

`endif

// File: tb/sptc_timing_chk.sv
// assertion checker on the ports of the polling timer block
// assumes a bind into sptc_timing, one clock core_clk and synchronous srst
`include "sptc_map.vh"
module sptc_timing_chk #(
    parameter [31:0] SERIAL_NUMBER = 32'h0
) (
    // clock and reset
    input logic        core_clk,
    input logic        srst,
    // register bus
    input logic [7:0]  avs_address,
    input logic        avs_read,
    input logic        avs_write,
    input logic [31:0] avs_writedata,
    input logic [31:0] avs_readdata,
    input logic        avs_waitrequest,
    // timing outputs and trims
    input logic        referenceTick,
    input logic        pollingOnPhase,
    input logic        masterPeriodEnd,
    input logic        activeWindow,
    input logic        dividedClockOutput,
    input logic        rfPathDisable,
    input logic [3:0]  ifAttenuationCode,
    input logic        injectionSideSelect,
    input logic [4:0]  signalStrengthSlopeTrim
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] tickGap;
    logic        tickSeen;
    logic        wrDone;
    logic [5:0]  idx;
    assign wrDone = avs_write && !avs_waitrequest;
    assign idx = avs_address[7:2];
    always @(posedge core_clk) begin
        if (srst) begin
            tickGap <= 16'h0000;
            tickSeen <= 1'b0;
        end else begin
            tickGap <= referenceTick ? 16'h0000 : tickGap + 16'h0001;
            tickSeen <= tickSeen | referenceTick;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    tick_gap_a: assert property (
        referenceTick && tickSeen |-> tickGap[5:0] == 6'h3f && tickGap < 16'h4000) else $error("tick spacing");
    phase_tick_a: assert property (
        $changed(pollingOnPhase) |-> referenceTick || $past(referenceTick)) else $error("phase off tick");
    end_on_a: assert property (
        masterPeriodEnd |-> (referenceTick || $past(referenceTick)) ##[0:1] pollingOnPhase) else $error("period end");
    active_end_a: assert property (
        $changed(activeWindow) |-> masterPeriodEnd || $past(masterPeriodEnd)) else $error("active change");
    rf_write_a: assert property (
        wrDone && idx == `SPTC_IDX_RF_CTRL |=> ##1
        {rfPathDisable, ifAttenuationCode} == $past(avs_writedata[4:0], 2)) else $error("rf trim");
    inj_write_a: assert property (
        wrDone && idx == `SPTC_IDX_LO_CTRL |=> ##1
        injectionSideSelect == $past(avs_writedata[4], 2)) else $error("injection side");
    trim_write_a: assert property (
        wrDone && idx == `SPTC_IDX_GAIN_TRIM |=> ##1
        signalStrengthSlopeTrim == $past(avs_writedata[4:0], 2)) else $error("slope trim");
    serial_read_a: assert property (
        avs_read && !avs_waitrequest && idx >= `SPTC_IDX_SERIAL0 && idx <= `SPTC_IDX_SERIAL3 |->
        avs_readdata == ((SERIAL_NUMBER >> {idx[1:0] - 2'b10, 3'b000}) & 32'h0000_00ff)) else $error("serial");
    tick_c: cover property (referenceTick);
    active_c: cover property ($rose(activeWindow));
    fast_clk_c: cover property ($changed(dividedClockOutput) ##1 $changed(dividedClockOutput));
endmodule // sptc_timing_chk

bind sptc_timing sptc_timing_chk #(.SERIAL_NUMBER(SERIAL_NUMBER)) u_chk (
    .core_clk(core_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .referenceTick(referenceTick), .pollingOnPhase(pollingOnPhase), .masterPeriodEnd(masterPeriodEnd),
    .activeWindow(activeWindow), .dividedClockOutput(dividedClockOutput), .rfPathDisable(rfPathDisable),
    .ifAttenuationCode(ifAttenuationCode), .injectionSideSelect(injectionSideSelect),
    .signalStrengthSlopeTrim(signalStrengthSlopeTrim));

// File: tb/test_sptc_timing.sv
// self-checking bench for the polling timer block with an integer register model
// assumes sptc_timing with an avalon-mm slave, 10 MHz core_clk, synchronous srst
`include "sptc_map.vh"
module test_sptc_timing;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] SN = 32'h3c1e_9a07;  // arbitrary value
    logic        core_clk, srst, avs_read, avs_write, avs_waitrequest, referenceTick, pollingOnPhase;
    logic        masterPeriodEnd, activeWindow, dividedClockOutput, rfPathDisable, injectionSideSelect;
    logic [7:0]  avs_address, v;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  ifAttenuationCode;
    logic [4:0]  signalStrengthSlopeTrim;
    int          failures = 0, checks = 0, cycles = 0, seed, i, d, mdl [64];
    int          rdq [$] = '{14, 15, 16, 17, 8, 63};
    int          refs [$] = '{1, 3, 0};

    sptc_timing #(.SERIAL_NUMBER(SN)) dut (
        .core_clk(core_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .referenceTick(referenceTick), .pollingOnPhase(pollingOnPhase), .masterPeriodEnd(masterPeriodEnd),
        .activeWindow(activeWindow), .dividedClockOutput(dividedClockOutput), .rfPathDisable(rfPathDisable),
        .ifAttenuationCode(ifAttenuationCode), .injectionSideSelect(injectionSideSelect),
        .signalStrengthSlopeTrim(signalStrengthSlopeTrim));

    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 90000) begin
            failures++;
            give_verdict();
        end
    end
    // ----------------------------------------------------------------
    // model, bus and compare tasks
    // ----------------------------------------------------------------
    function automatic int cnt(input int c, input int full);
        return c == 0 ? full : c;
    endfunction
    function automatic int refp();
        return 64 * cnt(mdl[8], 256);
    endfunction
    function automatic logic pick(input int k);
        case (k)
            0: return referenceTick;
            1: return pollingOnPhase;
            2: return dividedClockOutput;
            default: return activeWindow;
        endcase
    endfunction
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] dat, output logic [31:0] rd);
        int t = 0;
        logic w;
        @(posedge core_clk);
        avs_address <= {idx[5:0], 2'b00};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'($random(seed)), dat};
        do begin
            @(posedge core_clk);
            w = avs_waitrequest;
            rd = avs_readdata;
            t++;
        end while (w !== 1'b0 && t < 100);
        if (w !== 1'b0) chk("bus answer", w, 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (wr) mdl[idx[5:0]] = dat;
    endtask
    task automatic wr(input int idx, input int dat);
        logic [31:0] x;
        bus(1'b1, 8'(idx), 8'(dat), x);
    endtask
    task automatic run_len(input int k, input logic lvl, output int a, output int b);
        logic p;
        int t = 0;
        a = 0;
        b = 0;
        @(negedge core_clk);
        do begin
            p = pick(k);
            @(negedge core_clk);
            t++;
        end while (!(p !== lvl && pick(k) === lvl) && t < 80000);
        while (pick(k) === lvl && a < 40000) begin
            @(negedge core_clk);
            a++;
        end
        while (pick(k) !== lvl && b < 40000) begin
            @(negedge core_clk);
            b++;
        end
    endtask
    task automatic meas(input string nm, input int k, input logic lvl, input int ea, input int eb);
        int a, b;
        run_len(k, lvl, a, b);
        chk(nm, a, ea);
        chk(nm, b, eb);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        core_clk = 0;
        srst = 1;
        avs_read = 0;
        avs_write = 0;
        avs_address = 0;
        avs_writedata = 0;
        seed = 32'h5c70;
        mdl = '{default: 0};
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        repeat (3) @(negedge core_clk);
        chk("slope reset", signalStrengthSlopeTrim, 5'h0c);
        chk("rf reset", {rfPathDisable, ifAttenuationCode}, 5'h00);
        foreach (rdq[j]) begin
            bus(1'b0, 8'(rdq[j]), 8'h00, q);
            chk("read", q, (rdq[j] >= 14 && rdq[j] <= 17) ? (SN >> (8 * (rdq[j] - 14))) & 255 : 0);
        end
        for (i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            wr(8'h12, v);
            wr(8'h16, v & 8'h10);
            wr(8'h1b, v);
            repeat (3) @(negedge core_clk);
            chk("rf disable", rfPathDisable, v[4]);
            chk("if att", ifAttenuationCode, v[3:0]);
            chk("injection", injectionSideSelect, v[4]);
            chk("slope", signalStrengthSlopeTrim, v[4:0]);
        end
        foreach (refs[j]) begin
            wr(8'h08, refs[j]);
            meas("ref period", 0, 1'b0, refp() - 1, 1);
        end
        wr(8'h08, 1);
        wr(8'h09, 0);
        wr(8'h0a, 8'hc1);
        wr(8'h1f, 3);
        wr(8'h20, 0);
        meas("on off", 1, 1'b1, refp() * 3, refp() * 256);
        wr(8'h0a, 0);
        wr(8'h09, 1);
        wr(8'h1f, 1);
        wr(8'h0b, 8'he3);
        wr(8'h0c, 2);
        meas("active idle", 3, 1'b1, refp() * 2 * 3, refp() * 2 * 2);
        for (i = 0; i < 4; i++) begin
            d = (i == 0) ? 1 : (i == 1) ? 3 : (i == 2) ? 32'h102 : ($random(seed) & 32'hff) + 1;
            wr(8'h13, d & 255);
            wr(8'h14, (d >> 8) & 255);
            wr(8'h15, 8'ha0 | ((d >> 16) & 15));
            d = cnt(((mdl[21] & 15) << 16) | (mdl[20] << 8) | mdl[19], 1 << 20);
            meas("clock out", 2, 1'b1, d, d);
        end
        give_verdict();
    end
endmodule // test_sptc_timing
